// >>> verilog/rail_seq_defines.svh
// What this block does
// - with the rail-six option bit set, a high second control input selects 1.2 V for step-down rail six, else it has no effect.
// - when rail six runs with 25 mV steps the pin-selected voltage is 2.4 V instead of 1.2 V.
// - an asserted sleep input overrides the pin-selected voltage of rail six.
// - the third aux LDO source code picks pin one, two, five, four, three, three AND four or six for codes 000 to 110.
// - source code 111 feeds a constant one so the third aux LDO needs no pin.
// - mask bit 1 includes the combined second switch / first LDO power good in the third LDO condition, 1 excludes it.
// - mask bit 0 includes the B-one switch power good in the third LDO condition, 1 excludes it.
// - with the combine bit set the B-one switch enable also enables the B-two switch, else each runs normally.
// - with the swap bit set the B-two switch enable logic drives the first LDO and, unless the combine bit is set, the first LDO logic drives B-two.
// - the third aux LDO falling delay is none, 2, 4, 8, 16, 24, 32 or 64 ms for codes 000 to 111.
// - the third aux LDO rising delay uses the same encoding as the falling delay.
// - each programmed delay may differ from nominal by up to 10 percent.
// - B-one mask bits 7 and 6 include (0) or exclude (1) the aux LDO two and A-one switch power good.
// - B-one mask bits 5 to 0 include (0) or exclude (1) the power good of step-down rails six to one.
//
// header of register offsets, field positions, reset values and timing counts
// assumes a 250 MHz system clock
`ifndef RAIL_SEQ_DEFINES_SVH
`define RAIL_SEQ_DEFINES_SVH

// ****************************************
// register offsets and reset values
// ****************************************
`define OFS_THIRD_LDO_ENABLE_SELECT 8'h20
`define OFS_THIRD_LDO_DELAY_AND_SWAP 8'h21
`define OFS_SWITCH_B_ONE_GOOD_MASKS 8'h22
`define REG_RESET_VALUE 8'h00
`define READ_UNMAPPED 8'h00

// ****************************************
// field positions
// ****************************************
`define POS_RAIL_SIX_OPTION 7
`define POS_SOURCE_HI 4
`define POS_SOURCE_LO 2
`define POS_MASK_COMBINED 1
`define POS_MASK_SWITCH_B_ONE 0
`define POS_COMBINE 7
`define POS_SWAP 6
`define POS_FALL_HI 5
`define POS_FALL_LO 3
`define POS_RISE_HI 2
`define POS_RISE_LO 0

// ****************************************
// voltages and timing
// ****************************************
`define RAIL_SIX_LOW_MV 12'h4b0
`define RAIL_SIX_HIGH_MV 12'h960
`define NS_PER_MS 1000000
`define CLK_PERIOD_NS 4
`define CYCLES_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)
`define DLY_MS_0 8'h00
`define DLY_MS_1 8'h02
`define DLY_MS_2 8'h04
`define DLY_MS_3 8'h08
`define DLY_MS_4 8'h10
`define DLY_MS_5 8'h18
`define DLY_MS_6 8'h20
`define DLY_MS_7 8'h40

`endif

// >>> verilog/rail_seq_pkg.sv
// types shared by the sequencer files
// assumes nothing of its surroundings
`default_nettype none
package rail_seq_pkg;
  typedef logic [2:0] delay_code_t;
  typedef logic [7:0] reg_byte_t;
  // codes follow declaration order 000..111
  typedef enum logic [2:0] {
    SRC_PIN_ONE, SRC_PIN_TWO, SRC_PIN_FIVE, SRC_PIN_FOUR,
    SRC_PIN_THREE, SRC_PIN_THREE_AND_FOUR, SRC_PIN_SIX, SRC_ALWAYS
  } pin_source_t;
endpackage
`default_nettype wire

// >>> verilog/rail_delay_if.sv
// carrier between the sequencer top and its delay engines
// assumes both ends run on the same clock
`default_nettype none
interface rail_delay_if;
  import rail_seq_pkg::*;
  logic        cond;
  delay_code_t rise_code;
  delay_code_t fall_code;
  logic        enable;
  modport ctl (output cond, output rise_code, output fall_code, input enable);
  modport seq (input cond, input rise_code, input fall_code, output enable);
endinterface
`default_nettype wire

// >>> verilog/enable_delay.sv
// one rail enable with programmable rising and falling delays
// assumes a free running clock and a synchronous condition
`include "rail_seq_defines.svh"
`default_nettype none
module enable_delay
  import rail_seq_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // block side
  rail_delay_if.seq dly
);

  logic [31:0] cnt_ff;
  logic        en_ff;
  logic [31:0] target;
  logic [31:0] run_ff;

  // ****************************************
  // delay code to milliseconds
  // ****************************************
  function automatic logic [7:0] code_ms(input delay_code_t c);
    case (c)
      3'h0: code_ms = `DLY_MS_0;
      3'h1: code_ms = `DLY_MS_1;
      3'h2: code_ms = `DLY_MS_2;
      3'h3: code_ms = `DLY_MS_3;
      3'h4: code_ms = `DLY_MS_4;
      3'h5: code_ms = `DLY_MS_5;
      3'h6: code_ms = `DLY_MS_6;
      default: code_ms = `DLY_MS_7;
    endcase
  endfunction

  always_comb begin
    target = 32'(code_ms(dly.cond ? dly.rise_code : dly.fall_code)) * 32'(CYCLES_PER_MS);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      en_ff  <= 1'b0;
    end else if (dly.cond == en_ff) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff + 32'h1 >= target) begin
      cnt_ff <= 32'h0;
      en_ff  <= dly.cond;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign dly.enable = en_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_no_rise_without_cond;
    @(posedge mclk) disable iff (!rst_n) (!dly.cond && !en_ff) |=> !en_ff;
  endproperty
  a_no_rise_without_cond: assert property (p_no_rise_without_cond) else $error("enable rose without condition");

  property p_rise_zero;
    @(posedge mclk) disable iff (!rst_n) (dly.cond && !en_ff && dly.rise_code == 3'h0) |=> en_ff;
  endproperty
  a_rise_zero: assert property (p_rise_zero) else $error("zero rise delay not immediate");

  property p_fall_zero;
    @(posedge mclk) disable iff (!rst_n) (!dly.cond && en_ff && dly.fall_code == 3'h0) |=> !en_ff;
  endproperty
  a_fall_zero: assert property (p_fall_zero) else $error("zero fall delay not immediate");

  property p_restart;
    @(posedge mclk) disable iff (!rst_n) (dly.cond == en_ff) |=> (cnt_ff == 32'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("delay count not restarted");

  // independent run length of condition high while enable low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 32'h0;
    end else if (dly.cond && !en_ff) begin
      run_ff <= run_ff + 32'h1;
    end else begin
      run_ff <= 32'h0;
    end
  end

  property p_rise_timed;
    @(posedge mclk) disable iff (!rst_n) $rose(en_ff) |-> ($past(run_ff) + 32'h1 >= $past(target));
  endproperty
  a_rise_timed: assert property (p_rise_timed) else $error("enable rose before delay expired");

  c_rise: cover property (@(posedge mclk) disable iff (!rst_n) $rose(en_ff));
  c_fall: cover property (@(posedge mclk) disable iff (!rst_n) $fell(en_ff));
  c_abort: cover property (@(posedge mclk) disable iff (!rst_n) (cnt_ff != 32'h0) ##1 (cnt_ff == 32'h0) && !$changed(en_ff));

endmodule
`default_nettype wire

// >>> verilog/rail_enable_sequencer.sv
// enable sequencing for the third aux LDO and the B-one load switch,
// plus combine, swap and rail-six pin voltage option
// assumes register writes arrive as one-cycle strobes from the serial bus
// decoder and all pins are synchronous to mclk
`include "rail_seq_defines.svh"
`default_nettype none
module rail_enable_sequencer
  import rail_seq_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port from the serial bus decoder
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // control pins, bit 0 is pin one
  input  wire logic [5:0] control_pins,
  input  wire logic       second_control_input,
  input  wire logic       sleep_input,
  // power good inputs
  input  wire logic       power_good_combined,
  input  wire logic       power_good_switch_b_one,
  input  wire logic       power_good_aux_ldo_two,
  input  wire logic       power_good_switch_a_one,
  input  wire logic [5:0] power_good_step_rails,
  // settings of neighbouring logic
  input  wire logic       rail_six_step_25mv,
  input  wire logic       switch_b_one_source,
  input  wire logic [2:0] switch_b_one_rise_code,
  input  wire logic [2:0] switch_b_one_fall_code,
  input  wire logic       aux_ldo_one_logic_enable,
  input  wire logic       switch_b_two_logic_enable,
  // rail enables and rail-six voltage
  output logic            aux_ldo_three_enable,
  output logic            load_switch_b_one_enable,
  output logic            load_switch_b_two_enable,
  output logic            aux_ldo_one_enable,
  output logic            rail_six_pin_force,
  output logic     [11:0] rail_six_pin_mv
);

  reg_byte_t third_ldo_enable_select_ff;
  reg_byte_t third_ldo_delay_and_swap_ff;
  reg_byte_t switch_b_one_good_masks_ff;
  logic      third_src;
  logic      third_cond;
  logic      b_one_cond;
  logic      b_two_pre;
  logic      swap;
  logic      combine;

  rail_delay_if third_if ();
  rail_delay_if b_one_if ();

  // ****************************************
  // register file
  // ****************************************

  // write decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      third_ldo_enable_select_ff  <= `REG_RESET_VALUE;
      third_ldo_delay_and_swap_ff <= `REG_RESET_VALUE;
      switch_b_one_good_masks_ff  <= `REG_RESET_VALUE;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_THIRD_LDO_ENABLE_SELECT) begin
        third_ldo_enable_select_ff <= reg_wdata;
      end else if (reg_addr == `OFS_THIRD_LDO_DELAY_AND_SWAP) begin
        third_ldo_delay_and_swap_ff <= reg_wdata;
      end else if (reg_addr == `OFS_SWITCH_B_ONE_GOOD_MASKS) begin
        switch_b_one_good_masks_ff <= reg_wdata;
      end
    end
  end

  // read decode, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `READ_UNMAPPED;
    end else if (reg_rd) begin
      if (reg_addr == `OFS_THIRD_LDO_ENABLE_SELECT) begin
        reg_rdata <= third_ldo_enable_select_ff;
      end else if (reg_addr == `OFS_THIRD_LDO_DELAY_AND_SWAP) begin
        reg_rdata <= third_ldo_delay_and_swap_ff;
      end else if (reg_addr == `OFS_SWITCH_B_ONE_GOOD_MASKS) begin
        reg_rdata <= switch_b_one_good_masks_ff;
      end else begin
        reg_rdata <= `READ_UNMAPPED;
      end
    end
  end

  // ****************************************
  // third aux LDO enable condition
  // ****************************************

  // pin multiplexer
  function automatic logic pin_mux(input pin_source_t sel, input logic [5:0] pins);
    case (sel)
      SRC_PIN_ONE:            pin_mux = pins[0];
      SRC_PIN_TWO:            pin_mux = pins[1];
      SRC_PIN_FIVE:           pin_mux = pins[4];
      SRC_PIN_FOUR:           pin_mux = pins[3];
      SRC_PIN_THREE:          pin_mux = pins[2];
      SRC_PIN_THREE_AND_FOUR: pin_mux = pins[2] & pins[3];
      SRC_PIN_SIX:            pin_mux = pins[5];
      default:                pin_mux = 1'b1;
    endcase
  endfunction

  assign third_src = pin_mux(pin_source_t'(third_ldo_enable_select_ff[`POS_SOURCE_HI:`POS_SOURCE_LO]), control_pins);

  assign third_cond = third_src
                    & (third_ldo_enable_select_ff[`POS_MASK_COMBINED] | power_good_combined)
                    & (third_ldo_enable_select_ff[`POS_MASK_SWITCH_B_ONE] | power_good_switch_b_one);

  assign third_if.cond      = third_cond;
  assign third_if.rise_code = third_ldo_delay_and_swap_ff[`POS_RISE_HI:`POS_RISE_LO];
  assign third_if.fall_code = third_ldo_delay_and_swap_ff[`POS_FALL_HI:`POS_FALL_LO];

  enable_delay #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_third_delay (
    .mclk  (mclk),
    .rst_n (rst_n),
    .dly   (third_if.seq)
  );

  assign aux_ldo_three_enable = third_if.enable;

  // ****************************************
  // B-one load switch enable condition
  // ****************************************

  assign b_one_cond = switch_b_one_source
                    & (switch_b_one_good_masks_ff[7] | power_good_aux_ldo_two)
                    & (switch_b_one_good_masks_ff[6] | power_good_switch_a_one)
                    & (&(switch_b_one_good_masks_ff[5:0] | power_good_step_rails));

  assign b_one_if.cond      = b_one_cond;
  assign b_one_if.rise_code = switch_b_one_rise_code;
  assign b_one_if.fall_code = switch_b_one_fall_code;

  enable_delay #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_b_one_delay (
    .mclk  (mclk),
    .rst_n (rst_n),
    .dly   (b_one_if.seq)
  );

  assign load_switch_b_one_enable = b_one_if.enable;

  // ****************************************
  // swap and combine
  // ****************************************
  assign swap    = third_ldo_delay_and_swap_ff[`POS_SWAP];
  assign combine = third_ldo_delay_and_swap_ff[`POS_COMBINE];

  assign aux_ldo_one_enable = swap ? switch_b_two_logic_enable : aux_ldo_one_logic_enable;
  assign b_two_pre          = swap ? aux_ldo_one_logic_enable : switch_b_two_logic_enable;

  assign load_switch_b_two_enable = combine ? load_switch_b_one_enable : b_two_pre;

  // ****************************************
  // rail six pin voltage option
  // ****************************************

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rail_six_pin_force <= 1'b0;
      rail_six_pin_mv    <= 12'h000;
    end else if (third_ldo_enable_select_ff[`POS_RAIL_SIX_OPTION] && second_control_input && !sleep_input) begin
      rail_six_pin_force <= 1'b1;
      rail_six_pin_mv    <= rail_six_step_25mv ? `RAIL_SIX_HIGH_MV : `RAIL_SIX_LOW_MV;
    end else begin
      rail_six_pin_force <= 1'b0;
      rail_six_pin_mv    <= 12'h000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_six_low;
    @(posedge mclk) disable iff (!rst_n)
      (third_ldo_enable_select_ff[7] && second_control_input && !sleep_input && !rail_six_step_25mv)
      |=> (rail_six_pin_force && rail_six_pin_mv == 12'h4b0);
  endproperty
  a_six_low: assert property (p_six_low) else $error("rail six pin voltage not 1.2 V");

  property p_six_high;
    @(posedge mclk) disable iff (!rst_n)
      (third_ldo_enable_select_ff[7] && second_control_input && !sleep_input && rail_six_step_25mv)
      |=> (rail_six_pin_mv == 12'h960);
  endproperty
  a_six_high: assert property (p_six_high) else $error("rail six pin voltage not 2.4 V");

  property p_six_sleep;
    @(posedge mclk) disable iff (!rst_n) (sleep_input || !third_ldo_enable_select_ff[7]) |=> !rail_six_pin_force;
  endproperty
  a_six_sleep: assert property (p_six_sleep) else $error("rail six forced during sleep or option off");

  property p_src_pin_one;
    @(posedge mclk) disable iff (!rst_n) (third_ldo_enable_select_ff[4:2] == 3'h0) |-> (third_src == control_pins[0]);
  endproperty
  a_src_pin_one: assert property (p_src_pin_one) else $error("source 000 not pin one");

  property p_src_always;
    @(posedge mclk) disable iff (!rst_n) (third_ldo_enable_select_ff[4:2] == 3'h7) |-> third_src;
  endproperty
  a_src_always: assert property (p_src_always) else $error("source 111 not constant one");

  property p_mask_combined;
    @(posedge mclk) disable iff (!rst_n) (!third_ldo_enable_select_ff[1] && !power_good_combined) |-> !third_cond;
  endproperty
  a_mask_combined: assert property (p_mask_combined) else $error("combined good ignored while unmasked");

  property p_mask_b_one;
    @(posedge mclk) disable iff (!rst_n) (!third_ldo_enable_select_ff[0] && !power_good_switch_b_one) |-> !third_cond;
  endproperty
  a_mask_b_one: assert property (p_mask_b_one) else $error("B-one good ignored while unmasked");

  property p_combine;
    @(posedge mclk) disable iff (!rst_n) combine |-> (load_switch_b_two_enable == load_switch_b_one_enable);
  endproperty
  a_combine: assert property (p_combine) else $error("B-two not following B-one");

  property p_swap;
    @(posedge mclk) disable iff (!rst_n) (swap && !combine)
      |-> (aux_ldo_one_enable == switch_b_two_logic_enable && load_switch_b_two_enable == aux_ldo_one_logic_enable);
  endproperty
  a_swap: assert property (p_swap) else $error("swap not applied");

  property p_b_one_masks;
    @(posedge mclk) disable iff (!rst_n)
      (((~switch_b_one_good_masks_ff[5:0] & ~power_good_step_rails) != 6'h00)
      || (!switch_b_one_good_masks_ff[7] && !power_good_aux_ldo_two)
      || (!switch_b_one_good_masks_ff[6] && !power_good_switch_a_one)) |-> !b_one_cond;
  endproperty
  a_b_one_masks: assert property (p_b_one_masks) else $error("B-one unmasked good ignored");

  c_third_on: cover property (@(posedge mclk) disable iff (!rst_n) $rose(aux_ldo_three_enable));
  c_six_force: cover property (@(posedge mclk) disable iff (!rst_n) $rose(rail_six_pin_force));

endmodule
`default_nettype wire

// >>> tb/host_model.sv
// host side model: drives the register strobe port that stands for the serial bus
// assumes inputs are driven at the falling edge and sampled by the design on the rising edge
`default_nettype none
module host_model (
  // clock
  input  wire logic       mclk,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle strobes from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write strobe, held across one rising edge; idle address and data scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // one read strobe; data is registered at the read edge and taken a half cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the rail enable sequencer
// assumes the host model drives the register port and this module drives all levels
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rail_seq_pkg::*;

  // ****************************************
  // signals and the devices under test
  // ****************************************
  localparam int unsigned CPM = 10;
  localparam int DLY_MS [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic mclk, rst_n, reg_wr, reg_rd, sci, sleep, s25, b1src, a1le, b2le;
  logic pg_comb, pg_b1, pg_ldo2, pg_swa, three, b1, b2, a1, frc;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] pins, pg_steps;
  logic [2:0] b1_rise, b1_fall;
  logic [11:0] mv;
  int fails, compares;

  host_model host_model_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rail_enable_sequencer #(.CYCLES_PER_MS(CPM)) rail_enable_sequencer_i (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .control_pins(pins), .second_control_input(sci),
    .sleep_input(sleep), .power_good_combined(pg_comb), .power_good_switch_b_one(pg_b1),
    .power_good_aux_ldo_two(pg_ldo2), .power_good_switch_a_one(pg_swa), .power_good_step_rails(pg_steps),
    .rail_six_step_25mv(s25), .switch_b_one_source(b1src), .switch_b_one_rise_code(b1_rise),
    .switch_b_one_fall_code(b1_fall), .aux_ldo_one_logic_enable(a1le), .switch_b_two_logic_enable(b2le),
    .aux_ldo_three_enable(three), .load_switch_b_one_enable(b1), .load_switch_b_two_enable(b2),
    .aux_ldo_one_enable(a1), .rail_six_pin_force(frc), .rail_six_pin_mv(mv));

  // clock at 250 MHz
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // ****************************************
  // row table: ins = src a1le b2le sci sleep s25, ex = three b1 b2 a1 force
  // ****************************************
  typedef struct packed {
    logic [7:0] r20, r21, r22; logic [5:0] pins; logic [9:0] pg; logic [5:0] ins; logic [4:0] ex; logic [11:0] mv;
  } row_t;
  localparam row_t ROWS [25] = '{
    '{8'h80, 8'h00, 8'h00, 6'h01, 10'h3ff, 6'h34, 5'h1b, 12'h4b0}, '{8'h80, 8'h00, 8'h00, 6'h3e, 10'h3ff, 6'h35, 5'h0b, 12'h960},
    '{8'h84, 8'h00, 8'h00, 6'h02, 10'h3ff, 6'h36, 5'h1a, 12'h000}, '{8'h08, 8'h00, 8'h00, 6'h10, 10'h3ff, 6'h34, 5'h1a, 12'h000},
    '{8'h0c, 8'h00, 8'h00, 6'h08, 10'h3ff, 6'h30, 5'h1a, 12'h000}, '{8'h10, 8'h00, 8'h00, 6'h04, 10'h3ff, 6'h30, 5'h1a, 12'h000},
    '{8'h14, 8'h00, 8'h00, 6'h04, 10'h3ff, 6'h30, 5'h0a, 12'h000}, '{8'h14, 8'h00, 8'h00, 6'h0c, 10'h3ff, 6'h30, 5'h1a, 12'h000},
    '{8'h18, 8'h00, 8'h00, 6'h20, 10'h3ff, 6'h30, 5'h1a, 12'h000}, '{8'h1c, 8'h00, 8'h00, 6'h00, 10'h3ff, 6'h30, 5'h1a, 12'h000},
    '{8'h1c, 8'h00, 8'h00, 6'h00, 10'h1ff, 6'h30, 5'h0a, 12'h000}, '{8'h1e, 8'h00, 8'h00, 6'h00, 10'h1ff, 6'h30, 5'h1a, 12'h000},
    '{8'h1c, 8'h00, 8'h00, 6'h00, 10'h2ff, 6'h30, 5'h0a, 12'h000}, '{8'h1d, 8'h00, 8'h00, 6'h00, 10'h2ff, 6'h30, 5'h1a, 12'h000},
    '{8'h1f, 8'h00, 8'h00, 6'h00, 10'h37f, 6'h30, 5'h12, 12'h000}, '{8'h1f, 8'h00, 8'h80, 6'h00, 10'h37f, 6'h30, 5'h1a, 12'h000},
    '{8'h1f, 8'h00, 8'h80, 6'h00, 10'h3bf, 6'h30, 5'h12, 12'h000}, '{8'h1f, 8'h00, 8'h01, 6'h00, 10'h3df, 6'h30, 5'h12, 12'h000},
    '{8'h1f, 8'h00, 8'h20, 6'h00, 10'h3df, 6'h30, 5'h1a, 12'h000}, '{8'h1f, 8'h00, 8'h01, 6'h00, 10'h3fe, 6'h30, 5'h1a, 12'h000},
    '{8'h1f, 8'h00, 8'h00, 6'h00, 10'h3ff, 6'h10, 5'h12, 12'h000}, '{8'h1f, 8'h80, 8'h00, 6'h00, 10'h3ff, 6'h30, 5'h1e, 12'h000},
    '{8'h1f, 8'h80, 8'h00, 6'h00, 10'h3ff, 6'h18, 5'h12, 12'h000}, '{8'h1f, 8'h40, 8'h00, 6'h00, 10'h3ff, 6'h30, 5'h1c, 12'h000},
    '{8'h1f, 8'hc0, 8'h00, 6'h00, 10'h3ff, 6'h10, 5'h10, 12'h000}};
  localparam logic [7:0] PAT [3] = '{8'ha5, 8'h5a, 8'hff};

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // count cycles until both delayed enables reach lvl, allowing the ten percent spread
  task automatic meas(input logic lvl, input int n_exp);
    int n, t3, tb1, lo, hi;
    n = 0;
    t3 = -1;
    tb1 = -1;
    lo = n_exp - n_exp / 10;
    hi = n_exp + n_exp / 10 + 1;
    while (t3 < 0 || tb1 < 0) begin
      @(negedge mclk);
      n++;
      if (t3 < 0 && three === lvl) t3 = n;
      if (tb1 < 0 && b1 === lvl) tb1 = n;
      if (n > 1000) begin
        fails++;
        summarize();
      end
    end
    check("delay_three", 12'(t3 >= lo && t3 <= hi), 12'h001);
    check("delay_b_one", 12'(tb1 >= lo && tb1 <= hi), 12'h001);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fails = 0;
    compares = 0;
    rst_n = 1'b0;
    {pins, sci, sleep, s25, b1src, a1le, b2le, b1_rise, b1_fall} = '0;
    {pg_comb, pg_b1, pg_ldo2, pg_swa, pg_steps} = 10'h3ff;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    // ordinary cases from the table
    foreach (ROWS[i]) begin
      host_model_i.wr(8'h20, ROWS[i].r20);
      host_model_i.wr(8'h21, ROWS[i].r21);
      host_model_i.wr(8'h22, ROWS[i].r22);
      @(negedge mclk);
      pins = ROWS[i].pins;
      {pg_comb, pg_b1, pg_ldo2, pg_swa, pg_steps} = ROWS[i].pg;
      {b1src, a1le, b2le, sci, sleep, s25} = ROWS[i].ins;
      repeat (3) @(negedge mclk);
      check("enables", {7'h00, three, b1, b2, a1, frc}, {7'h00, ROWS[i].ex});
      check("rail_six_mv", mv, ROWS[i].mv);
    end
    // every delay code on both edges
    host_model_i.wr(8'h20, 8'h1d);
    host_model_i.wr(8'h22, 8'h00);
    {pg_comb, b1src, sci, sleep, s25} = '0;
    {pg_b1, pg_ldo2, pg_swa, pg_steps} = 9'h1ff;
    for (int c = 0; c < 8; c++) begin
      host_model_i.wr(8'h21, {2'b00, 3'(c), 3'(c)});
      @(negedge mclk);
      {b1_rise, b1_fall, pg_comb, b1src} = {3'(c), 3'(c), 2'b11};
      meas(1'b1, (DLY_MS[c] == 0) ? 1 : DLY_MS[c] * int'(CPM));
      @(negedge mclk);
      {pg_comb, b1src} = 2'b00;
      meas(1'b0, (DLY_MS[c] == 0) ? 1 : DLY_MS[c] * int'(CPM));
    end
    // condition drops for one cycle before expiry: count restarts
    host_model_i.wr(8'h21, 8'h09);
    @(negedge mclk);
    {b1_rise, b1_fall, pg_comb, b1src} = {3'h1, 3'h1, 2'b11};
    repeat (15) @(negedge mclk);
    check("early_enables", {10'h000, three, b1}, 12'h000);
    {pg_comb, b1src} = 2'b00;
    @(negedge mclk);
    {pg_comb, b1src} = 2'b11;
    meas(1'b1, 20);
    // reset in mid-run with rails up, rail six forced and read data held
    host_model_i.wr(8'h20, 8'h9d);
    host_model_i.rd(8'h20, d);
    check("pre_reset_read", {4'h0, d}, 12'h09d);
    sci = 1'b1;
    repeat (3) @(negedge mclk);
    check("pre_reset_mv", mv, 12'h4b0);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("reset_outputs", {9'h000, three, b1, frc}, 12'h000);
    check("reset_mv", mv, 12'h000);
    check("reset_rdata", {4'h0, reg_rdata}, 12'h000);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_model_i.rd(8'h20 + 8'(i), d);
      check("reset_value", {4'h0, d}, 12'h000);
    end
    // patterns a5, 5a and ff written and read back, unmapped places ignored and read as zero
    for (int i = 0; i < 3; i++) host_model_i.wr(8'h20 + 8'(i), PAT[i]);
    host_model_i.wr(8'h23, 8'h77);
    host_model_i.wr(8'h1f, 8'h77);
    for (int i = 0; i < 3; i++) begin
      host_model_i.rd(8'h20 + 8'(i), d);
      check("readback", {4'h0, d}, {4'h0, PAT[i]});
    end
    host_model_i.rd(8'h23, d);
    check("unmapped_23", {4'h0, d}, 12'h000);
    host_model_i.rd(8'h1f, d);
    check("unmapped_1f", {4'h0, d}, 12'h000);
    summarize();
  end
endmodule
`default_nettype wire
